// ### rtl/vffc_pkg.sv
// Constants, field layouts and carrier types for the video format and framing control block.
// Assumes an APB master with 32-bit data and a front end that measures rasters and finds timing words.
package vffc_pkg;
    // Register indices; the byte address is four times the index.
    localparam logic [5:0] IDX_TARGET_FMT = 6'h0b;
    localparam logic [5:0] IDX_DETECT_FMT = 6'h0c;
    localparam logic [5:0] IDX_PATTERN = 6'h0d;
    localparam logic [5:0] IDX_ALIGN = 6'h10;
    localparam int ADDR_LSB = 2;

    // Field positions of target_format_config.
    localparam int TF_HD_LOCK = 5;
    localparam int TF_SD_LOCK = 6;
    localparam int TF_FRM_MODE = 7;
    // Field positions of detected_format_status.
    localparam int DF_H = 5;
    localparam int DF_V = 6;
    localparam int DF_F = 7;
    // Field positions of pattern_test_control.
    localparam int PT_GEN_ON = 6;
    localparam int PT_PASS = 7;
    localparam int PS_HD = 5;
    localparam int PS_PAL = 4;
    // Field positions of alignment_control.
    localparam int AL_REALIGN = 0;
    localparam int AL_FLAG = 1;
    // Bits of the timing reference word.
    localparam int TRS_H = 6;
    localparam int TRS_V = 7;
    localparam int TRS_F = 8;

    localparam logic FRM_MODE_RESET = 1'b1;

    // Format codes.
    localparam logic [4:0] FMT_NONE = 5'h00;
    localparam logic [4:0] FMT_525_54 = 5'h01;
    localparam logic [4:0] FMT_525_36 = 5'h02;
    localparam logic [4:0] FMT_525_27 = 5'h03;
    localparam logic [4:0] FMT_625_54 = 5'h09;
    localparam logic [4:0] FMT_625_36 = 5'h0a;
    localparam logic [4:0] FMT_625_27 = 5'h0b;
    localparam logic [4:0] FMT_1125_30I_1035 = 5'h11;
    localparam logic [4:0] FMT_1125_30I = 5'h12;
    localparam logic [4:0] FMT_1125_30P = 5'h13;
    localparam logic [4:0] FMT_750_60P = 5'h14;
    localparam logic [4:0] FMT_1125_25I = 5'h19;
    localparam logic [4:0] FMT_1125_25P = 5'h1a;
    localparam logic [4:0] FMT_1250_25I = 5'h1c;
    localparam logic [4:0] FMT_1125_24P = 5'h1d;
    localparam int FMT_HD_BIT = 4;
    localparam int FMT_PAL_BIT = 3;

    // Raster totals.
    localparam logic [10:0] LINES_525 = 11'd525;
    localparam logic [10:0] LINES_625 = 11'd625;
    localparam logic [10:0] LINES_750 = 11'd750;
    localparam logic [10:0] LINES_1125 = 11'd1125;
    localparam logic [10:0] LINES_1250 = 11'd1250;
    localparam logic [10:0] ACTIVE_1035 = 11'd1035;
    localparam logic [11:0] SMP_3432 = 12'd3432;
    localparam logic [11:0] SMP_2288 = 12'd2288;
    localparam logic [11:0] SMP_1716 = 12'd1716;
    localparam logic [11:0] SMP_3456 = 12'd3456;
    localparam logic [11:0] SMP_2304 = 12'd2304;
    localparam logic [11:0] SMP_1728 = 12'd1728;
    localparam logic [11:0] SMP_2200 = 12'd2200;
    localparam logic [11:0] SMP_2640 = 12'd2640;
    localparam logic [11:0] SMP_2376 = 12'd2376;
    localparam logic [11:0] SMP_2750 = 12'd2750;
    localparam logic [11:0] SMP_1650 = 12'd1650;

    // Test pattern kinds in the two low select bits.
    localparam logic [1:0] PAT_BLACK = 2'h0;
    localparam logic [1:0] PAT_PLL = 2'h1;
    localparam logic [1:0] PAT_EQ = 2'h2;
    localparam logic [1:0] PAT_BARS = 2'h3;
    // Raster bits [3:2] of a standard definition 27 MHz pattern.
    localparam logic [1:0] SD_RASTER_27 = 2'h2;

    // Rate search ranges handed to the frequency acquisition logic.
    localparam logic [1:0] SEARCH_SD = 2'h1;
    localparam logic [1:0] SEARCH_HD = 2'h2;
    localparam logic [1:0] SEARCH_BOTH = 2'h3;

    typedef struct packed {
        logic valid;
        logic [10:0] lines;
        logic [10:0] active_lines;
        logic [11:0] samples;
        logic progressive;
        logic rate_hd;
    } vffc_meas_t;

    typedef struct packed {
        logic valid;
        logic aligned;
        logic [9:0] word;
    } vffc_trs_t;
endpackage : vffc_pkg

// ### rtl/vffc_top.sv
// Video format and framing control: configuration and status registers with their control logic.
// Assumes an APB master on clk, and a front end on clk reporting raster measurements and timing words.
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Nonzero target code confines processing to it.
// - Target code names one format, never ranges.
// - Code bit 4 means HD, bit 3 PAL.
// - 525-line codes 00001, 00010, 00011.
// - 625-line codes 01001, 01010, 01011.
// - 1125-line 30 frame codes 10001, 10010, 10011.
// - Other HD codes 11001, 11010, 11100, 11101, 10100.
// - High definition lock alone restricts search to HD.
// - Standard definition lock alone restricts search to SD.
// - Both locks clear searches both ranges.
// - Lock first timing word; flag off-boundary ones.
// - With policy bit clear, realign request realigns at every timing word.
// - Policy bit makes flag drive realign request.
// - Alignment policy bit resets to one.
// - Detected format code is reported read-only.
// - Detection ignores the 1.001 rate difference.
// - H, V, F copy timing word bits 6-8.
// - Pattern select picks the generated pattern.
// - HD bars and two SD patterns are self-test.
// - Generator enable turns on pattern and self-test.
// - Pass bit reads one only on pass.
// - Select bit 5 HD; low bits pattern kind.
module vffc_top import vffc_pkg::*; (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire vffc_meas_t meas,
    input wire vffc_trs_t trs,
    input wire logic realign_input,
    input wire logic bist_done,
    input wire logic bist_ok,
    output logic off_boundary_sync_flag,
    output logic realign_strobe,
    output logic [1:0] rate_search,
    output logic [4:0] accepted_format,
    output logic format_accepted,
    output logic [5:0] pattern_sel,
    output logic pattern_gen_on,
    output logic bist_capable
);

    typedef struct packed {
        logic [4:0] cfg_fmt;
        logic hd_lock;
        logic sd_lock;
        logic frm_mode;
        logic realign_sw;
        logic [4:0] det_fmt;
        logic h;
        logic v;
        logic f;
        logic [5:0] pat_sel;
        logic pat_on;
        logic pass;
        logic locked;
        logic flag;
        logic realign;
        logic [1:0] search;
        logic accept;
        logic capable;
        logic ready;
        logic slverr;
        logic [31:0] rdata;
    } vffc_state_t;

    vffc_state_t st;
    vffc_state_t next_st;

    // Maps a measured raster to its format code; the word rate is not looked at.
    function automatic logic [4:0] fmt_code(input vffc_meas_t m);
        logic [4:0] c;
        c = FMT_NONE;
        if (m.lines == LINES_525) begin
            if (m.samples == SMP_3432) c = FMT_525_54;
            else if (m.samples == SMP_2288) c = FMT_525_36;
            else if (m.samples == SMP_1716) c = FMT_525_27;
        end else if (m.lines == LINES_625) begin
            if (m.samples == SMP_3456) c = FMT_625_54;
            else if (m.samples == SMP_2304) c = FMT_625_36;
            else if (m.samples == SMP_1728) c = FMT_625_27;
        end else if (m.lines == LINES_1125) begin
            if (m.samples == SMP_2200) begin
                if (m.progressive) c = FMT_1125_30P;
                else if (m.active_lines == ACTIVE_1035) c = FMT_1125_30I_1035;
                else c = FMT_1125_30I;
            end else if (m.samples == SMP_2640) begin
                c = m.progressive ? FMT_1125_25P : FMT_1125_25I;
            end else if (m.samples == SMP_2750 && m.progressive) begin
                c = FMT_1125_24P;
            end
        end else if (m.lines == LINES_1250 && m.samples == SMP_2376 && !m.progressive) begin
            c = FMT_1250_25I;
        end else if (m.lines == LINES_750 && m.samples == SMP_1650 && m.progressive) begin
            c = FMT_750_60P;
        end
        return c;
    endfunction : fmt_code

    // True when the code is one that the search range lets through.
    function automatic logic in_range(input logic [4:0] c, input logic [1:0] s);
        logic r;
        r = c[FMT_HD_BIT] ? s[1] : s[0];
        return r;
    endfunction : in_range

    // True when the selected pattern doubles as self-test data.
    function automatic logic selftest_pattern(input logic [5:0] p);
        logic r;
        if (p[PS_HD]) r = (p[1:0] == PAT_BARS);
        else if (p[3:2] != SD_RASTER_27) r = 1'b0;
        else r = p[PS_PAL] ? (p[1:0] == PAT_PLL) : (p[1:0] == PAT_BARS);
        return r;
    endfunction : selftest_pattern

    logic apb_setup;
    logic apb_commit;
    logic [5:0] idx;
    logic wr_lane;
    logic realign_eff;
    logic [4:0] meas_code;
    assign apb_setup = psel && !penable;
    assign apb_commit = psel && penable && st.ready;
    assign idx = paddr[ADDR_LSB +: 6];
    assign wr_lane = apb_commit && pwrite && pstrb[0];
    assign meas_code = fmt_code(meas);
    // The policy bit lets the off-boundary flag act as the realign request.
    assign realign_eff = st.frm_mode ? st.flag : (st.realign_sw || realign_input);

    always_comb begin
        next_st = st;
        next_st.realign = 1'b0;
        // APB: answer in the access phase, one cycle after setup.
        next_st.ready = apb_setup;
        next_st.slverr = 1'b0;
        next_st.rdata = 32'h0000_0000;
        if (apb_setup) begin
            case (idx)
                IDX_TARGET_FMT: begin
                    next_st.rdata[7:0] = {st.frm_mode, st.sd_lock, st.hd_lock, st.cfg_fmt};
                end
                IDX_DETECT_FMT: begin
                    next_st.rdata[7:0] = {st.f, st.v, st.h, st.det_fmt};
                end
                IDX_PATTERN: begin
                    next_st.rdata[7:0] = {st.pass, st.pat_on, st.pat_sel};
                end
                IDX_ALIGN: begin
                    next_st.rdata[AL_REALIGN] = st.realign_sw;
                    next_st.rdata[AL_FLAG] = st.flag;
                end
                default: begin
                    next_st.slverr = 1'b1;
                end
            endcase
        end
        if (wr_lane) begin
            case (idx)
                IDX_TARGET_FMT: begin
                    next_st.cfg_fmt = pwdata[4:0];
                    next_st.hd_lock = pwdata[TF_HD_LOCK];
                    next_st.sd_lock = pwdata[TF_SD_LOCK];
                    next_st.frm_mode = pwdata[TF_FRM_MODE];
                end
                IDX_PATTERN: begin
                    next_st.pat_sel = pwdata[5:0];
                    next_st.pat_on = pwdata[PT_GEN_ON];
                    if (pwdata[PT_GEN_ON] && !st.pat_on) begin
                        next_st.pass = 1'b0;
                    end
                end
                IDX_ALIGN: begin
                    next_st.realign_sw = pwdata[AL_REALIGN];
                end
                default: begin
                end
            endcase
        end
        // Rate search range for frequency acquisition and detection.
        if (next_st.hd_lock && !next_st.sd_lock) begin
            next_st.search = SEARCH_HD;
        end else if (next_st.sd_lock && !next_st.hd_lock) begin
            next_st.search = SEARCH_SD;
        end else begin
            next_st.search = SEARCH_BOTH;
        end
        // Detected format; bit 4 HD and bit 3 PAL come from the code table.
        if (meas.valid) begin
            next_st.det_fmt = in_range(meas_code, next_st.search) ? meas_code : FMT_NONE;
        end
        next_st.accept = (next_st.det_fmt != FMT_NONE)
            && (next_st.cfg_fmt == FMT_NONE || next_st.cfg_fmt == next_st.det_fmt);
        // Timing word handling: flags, framing policy.
        if (trs.valid) begin
            next_st.h = trs.word[TRS_H];
            next_st.v = trs.word[TRS_V];
            next_st.f = trs.word[TRS_F];
            if (realign_eff || !st.locked) begin
                next_st.realign = 1'b1;
                next_st.locked = 1'b1;
                next_st.flag = 1'b0;
            end else begin
                next_st.flag = !trs.aligned;
            end
        end
        // Self-test result is only meaningful while the generator runs.
        next_st.capable = selftest_pattern(next_st.pat_sel);
        if (!next_st.pat_on) begin
            next_st.pass = 1'b0;
        end else if (bist_done && st.capable) begin
            next_st.pass = bist_ok;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
            st.frm_mode <= FRM_MODE_RESET;
            st.search <= SEARCH_BOTH;
        end else begin
            st <= next_st;
        end
    end

    assign prdata = st.rdata;
    assign pready = st.ready;
    assign pslverr = st.slverr;
    assign off_boundary_sync_flag = st.flag;
    assign realign_strobe = st.realign;
    assign rate_search = st.search;
    assign accepted_format = st.det_fmt;
    assign format_accepted = st.accept;
    assign pattern_sel = st.pat_sel;
    assign pattern_gen_on = st.pat_on;
    assign bist_capable = st.capable;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_search_high_def_lock: assert property (st.hd_lock && !st.sd_lock |-> rate_search == SEARCH_HD)
        else $error("HD lock did not restrict the search.");
    chk_search_std_def_lock: assert property (st.sd_lock && !st.hd_lock |-> rate_search == SEARCH_SD)
        else $error("SD lock did not restrict the search.");
    chk_search_both: assert property (!st.hd_lock && !st.sd_lock |-> rate_search == SEARCH_BOTH)
        else $error("Search not widened with both locks clear.");
    chk_flag_set: assert property (trs.valid && st.locked && !realign_eff && !trs.aligned
        |=> off_boundary_sync_flag && !realign_strobe)
        else $error("Off-boundary timing word did not raise the flag.");
    chk_flag_hold: assert property (!trs.valid |=> $stable(off_boundary_sync_flag))
        else $error("Off-boundary flag moved without a timing word.");
    chk_realign_every: assert property (trs.valid && realign_eff |=> realign_strobe && !off_boundary_sync_flag)
        else $error("Realign request did not realign.");
    chk_mode_flag_loop: assert property (st.frm_mode && st.flag && trs.valid |=> realign_strobe)
        else $error("Policy bit did not loop the flag into realign.");
    chk_hvf_copy: assert property (trs.valid |=> st.h == $past(trs.word[TRS_H]) && st.v == $past(trs.word[TRS_V])
        && st.f == $past(trs.word[TRS_F]))
        else $error("H, V or F not copied from the timing word.");
    chk_detect_code: assert property (meas.valid && in_range(meas_code, next_st.search)
        |=> accepted_format == $past(meas_code))
        else $error("Detected format differs from measured raster.");
    chk_confine_target: assert property (format_accepted |-> st.cfg_fmt == FMT_NONE || st.cfg_fmt == st.det_fmt)
        else $error("Format accepted outside the target.");
    chk_pass_idle: assert property (!pattern_gen_on |-> !st.pass)
        else $error("Pass bit set with the generator off.");
    chk_apb_answer: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("APB answer not given in the access phase.");

    cov_off_boundary: cover property (trs.valid && st.locked && !trs.aligned && !realign_eff);
    cov_realign: cover property (trs.valid && realign_eff && st.locked);
    cov_bist_pass: cover property (pattern_gen_on && bist_done && bist_ok && st.capable);
    cov_confined: cover property (st.cfg_fmt != FMT_NONE && format_accepted);

endmodule : vffc_top

`default_nettype wire

// ### verif/vffc_front.sv
// Behavioural model of the video front end: raster measurements, timing words and self-test results.
// Assumes the bench calls its tasks from a process that follows clk.
`timescale 1ns/1ps
`default_nettype none
module vffc_front import vffc_pkg::*; (
    input wire logic clk,
    output var vffc_meas_t meas,
    output var vffc_trs_t trs,
    output var logic bist_done,
    output var logic bist_ok
);
    initial begin
        meas = '0;
        trs = '0;
        bist_done = 1'b0;
        bist_ok = 1'b0;
    end

    // Outside a pulse the fields show inverted data so that stale values are never trusted.
    task automatic send_meas(input logic [10:0] ln, input logic [10:0] act, input logic [11:0] smp,
        input logic prog, input logic hd);
        @(posedge clk);
        meas <= '{1'b1, ln, act, smp, prog, hd};
        @(posedge clk);
        meas <= '{1'b0, ~ln, ~act, ~smp, ~prog, ~hd};
    endtask : send_meas

    task automatic send_trs(input logic al, input logic [9:0] w);
        @(posedge clk);
        trs <= '{1'b1, al, w};
        @(posedge clk);
        trs <= '{1'b0, ~al, ~w};
    endtask : send_trs

    task automatic send_bist(input logic ok);
        @(posedge clk);
        bist_ok <= ok;
        bist_done <= 1'b1;
        @(posedge clk);
        bist_done <= 1'b0;
    endtask : send_bist
endmodule : vffc_front
`default_nettype wire

// ### verif/video_format_framing_control_bench.sv
// Self-checking bench for the video format and framing control block.
// Assumes the front end model vffc_front and the package vffc_pkg.
`timescale 1ns/1ps
`default_nettype none
module video_format_framing_control_bench import vffc_pkg::*;;
    typedef struct packed {
        logic [4:0] code;
        logic [10:0] ln;
        logic [10:0] act;
        logic [11:0] smp;
        logic prog;
    } vffc_row_t;
    localparam vffc_row_t ROWS [14] = '{
        '{FMT_525_54, LINES_525, 11'd487, SMP_3432, 1'b0}, '{FMT_525_36, LINES_525, 11'd487, SMP_2288, 1'b0},
        '{FMT_525_27, LINES_525, 11'd487, SMP_1716, 1'b0}, '{FMT_625_54, LINES_625, 11'd577, SMP_3456, 1'b0},
        '{FMT_625_36, LINES_625, 11'd577, SMP_2304, 1'b0}, '{FMT_625_27, LINES_625, 11'd577, SMP_1728, 1'b0},
        '{FMT_1125_30I_1035, LINES_1125, ACTIVE_1035, SMP_2200, 1'b0},
        '{FMT_1125_30I, LINES_1125, 11'd1080, SMP_2200, 1'b0}, '{FMT_1125_30P, LINES_1125, 11'd1080, SMP_2200, 1'b1},
        '{FMT_1125_25I, LINES_1125, 11'd1080, SMP_2640, 1'b0}, '{FMT_1125_25P, LINES_1125, 11'd1080, SMP_2640, 1'b1},
        '{FMT_1250_25I, LINES_1250, 11'd1080, SMP_2376, 1'b0}, '{FMT_1125_24P, LINES_1125, 11'd1080, SMP_2750, 1'b1},
        '{FMT_750_60P, LINES_750, 11'd720, SMP_1650, 1'b1}};
    localparam logic [5:0] SELS [7] = '{6'h23, 6'h0b, 6'h19, 6'h3f, 6'h0a, 6'h22, 6'h01};
    localparam logic CAPS [7] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
    localparam logic [7:0] A_TGT = {IDX_TARGET_FMT, 2'b00};
    localparam logic [7:0] A_DET = {IDX_DETECT_FMT, 2'b00};
    localparam logic [7:0] A_PAT = {IDX_PATTERN, 2'b00};
    localparam logic [7:0] A_ALN = {IDX_ALIGN, 2'b00};
    logic clk = 1'b0;
    logic rst_n, psel, penable, pwrite, pready, pslverr, realign_input, bist_done, bist_ok;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    vffc_meas_t meas;
    vffc_trs_t trs;
    logic off_boundary_sync_flag, realign_strobe, format_accepted, pattern_gen_on, bist_capable, err;
    logic [1:0] rate_search;
    logic [4:0] accepted_format;
    logic [5:0] pattern_sel;
    int n_fail = 0;
    int checks_done = 0;
    int i;

    always #10 clk = ~clk;

    vffc_top vffc_top_i (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .meas(meas), .trs(trs), .realign_input(realign_input), .bist_done(bist_done), .bist_ok(bist_ok),
        .off_boundary_sync_flag(off_boundary_sync_flag), .realign_strobe(realign_strobe),
        .rate_search(rate_search), .accepted_format(accepted_format), .format_accepted(format_accepted),
        .pattern_sel(pattern_sel), .pattern_gen_on(pattern_gen_on), .bist_capable(bist_capable));
    vffc_front vffc_front_i (.clk(clk), .meas(meas), .trs(trs), .bist_done(bist_done), .bist_ok(bist_ok));

    task automatic wrap_up();
        $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    // One APB transfer; the request stands until pready is seen at a rising edge.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (k = 0; k < 16; k++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (k == 16) begin
            n_fail++;
            $display("mismatch at %0t: no pready", $time);
            wrap_up();
        end else begin
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d});
    endtask : wr

    task automatic rdck(input logic [7:0] a, input logic [31:0] exp, input string what);
        apb(1'b0, a, 32'h0);
        chk(rd, exp, what);
    endtask : rdck

    task automatic trs_go(input logic al, input logic [9:0] w);
        vffc_front_i.send_trs(al, w);
        #1;
    endtask : trs_go

    task automatic meas_go(input vffc_row_t r, input logic hd);
        vffc_front_i.send_meas(r.ln, r.act, r.smp, r.prog, hd);
        #1;
    endtask : meas_go

    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask : settle

    initial begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pstrb = 4'hf;
        realign_input = 1'b0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        rdck(A_TGT, 32'h80, "target reset");
        rdck(A_DET, 32'h0, "detected reset");
        rdck(A_PAT, 32'h0, "pattern reset");
        chk(rate_search, SEARCH_BOTH, "search reset");
        $display("test reset done");
        wr(A_TGT, 8'h00);
        trs_go(1'b1, 10'h200);
        chk(realign_strobe, 1'b1, "first lock");
        for (i = 0; i < 2; i++) begin
            trs_go(1'b0, 10'h200);
            chk({realign_strobe, off_boundary_sync_flag}, 2'b01, "off boundary");
        end
        rdck(A_ALN, 32'h2, "flag register");
        trs_go(1'b1, 10'h200);
        chk(off_boundary_sync_flag, 1'b0, "flag cleared");
        @(posedge clk);
        realign_input <= 1'b1;
        for (i = 0; i < 2; i++) begin
            trs_go(1'b0, 10'h200);
            chk({realign_strobe, off_boundary_sync_flag}, 2'b10, "realign each");
        end
        @(posedge clk);
        realign_input <= 1'b0;
        wr(A_ALN, 8'h01);
        rdck(A_ALN, 32'h1, "realign register");
        trs_go(1'b0, 10'h200);
        chk({realign_strobe, off_boundary_sync_flag}, 2'b10, "software realign");
        wr(A_ALN, 8'h00);
        wr(A_TGT, 8'h80);
        trs_go(1'b0, 10'h200);
        chk({realign_strobe, off_boundary_sync_flag}, 2'b01, "policy flag");
        trs_go(1'b0, 10'h200);
        chk({realign_strobe, off_boundary_sync_flag}, 2'b10, "policy realign");
        for (i = 0; i < 3; i++) begin
            trs_go(1'b1, 10'h040 << i);
            rdck(A_DET, 32'h20 << i, "timing bits");
        end
        $display("test alignment done");
        for (i = 0; i < 14; i++) begin
            meas_go(ROWS[i], i[0]);
            chk(accepted_format, ROWS[i].code, "detected code");
            chk(accepted_format[4], ROWS[i].ln > 11'd625, "hd bit");
            chk(format_accepted, 1'b1, "unconfined");
            rdck(A_DET, {24'h0, 3'b100, ROWS[i].code}, "detected register");
        end
        meas_go(ROWS[6], 1'b1);
        chk(accepted_format, FMT_1125_30I_1035, "rate variant");
        wr(A_TGT, {3'b100, FMT_1125_30P});
        meas_go(ROWS[8], 1'b0);
        chk(format_accepted, 1'b1, "target match");
        meas_go(ROWS[7], 1'b0);
        chk(format_accepted, 1'b0, "target other");
        wr(A_TGT, 8'ha0);
        settle();
        chk(rate_search, SEARCH_HD, "hd lock");
        meas_go(ROWS[0], 1'b0);
        chk(accepted_format, FMT_NONE, "sd refused");
        wr(A_TGT, 8'hc0);
        settle();
        chk(rate_search, SEARCH_SD, "sd lock");
        meas_go(ROWS[8], 1'b1);
        chk(accepted_format, FMT_NONE, "hd refused");
        meas_go(ROWS[5], 1'b0);
        chk(accepted_format, FMT_625_27, "sd kept");
        wr(A_TGT, 8'h80);
        settle();
        chk(rate_search, SEARCH_BOTH, "both");
        $display("test formats done");
        for (i = 0; i < 7; i++) begin
            wr(A_PAT, {2'b01, SELS[i]});
            settle();
            chk({pattern_gen_on, pattern_sel}, {1'b1, SELS[i]}, "pattern");
            chk(bist_capable, CAPS[i], "self-test data");
            rdck(A_PAT, {24'h0, 2'b01, SELS[i]}, "pattern register");
        end
        wr(A_PAT, 8'h23);
        wr(A_PAT, 8'h63);
        vffc_front_i.send_bist(1'b1);
        rdck(A_PAT, 32'he3, "pass");
        wr(A_PAT, 8'h23);
        rdck(A_PAT, 32'h23, "pass off");
        wr(A_PAT, 8'h63);
        vffc_front_i.send_bist(1'b0);
        rdck(A_PAT, 32'h63, "fail");
        wr(A_PAT, 8'he3);
        rdck(A_PAT, 32'h63, "pass read only");
        $display("test pattern done");
        pstrb <= 4'he;
        wr(A_PAT, 8'h00);
        pstrb <= 4'hf;
        rdck(A_PAT, 32'h63, "strobe off");
        apb(1'b0, 8'h3c, 32'h0);
        chk({err, rd}, {1'b1, 32'h0}, "unmapped");
        wr(A_DET, 8'h1f);
        rdck(A_DET, {24'h0, 3'b100, FMT_625_27}, "read only");
        $display("test bus done");
        wrap_up();
    end

    initial begin
        repeat (50000) @(posedge clk);
        n_fail++;
        wrap_up();
    end
endmodule : video_format_framing_control_bench
`default_nettype wire
